// file: common/tcm_defines.vh
`ifndef TCM_DEFINES_VH
`define TCM_DEFINES_VH
// ----------------------------------------------------------------------
// Register map of the Wishbone slave (byte addresses)
// ----------------------------------------------------------------------
`define TCM_OFS_SWVEC 4'h0
`define TCM_OFS_STAT 4'h4
`define TCM_OFS_MASK 4'h8
`define TCM_OFS_STATE 4'hC
`define TCM_SWVEC_ARM 7
`define TCM_STAT_SWEND 0
`define TCM_STAT_HWEND 1
// ----------------------------------------------------------------------
// Memory layout and field positions
// ----------------------------------------------------------------------
`define TCM_VEC_BASE 24'h00_0400
`define TCM_RAM_HIGH 8'hFF
`define TCM_RI_STRIDE 24'h00_000C
`define TCM_MRA_SM 7:6
`define TCM_MRA_DM 5:4
`define TCM_MRA_MD 3:2
`define TCM_MRA_DTS 1
`define TCM_MRA_SZ 0
`define TCM_MRB_CHAIN 7
`define TCM_MRB_EACH 6
`define TCM_MD_NORMAL 2'b00
`define TCM_MD_REPEAT 2'b01
`define TCM_MD_BLOCK 2'b10
// ----------------------------------------------------------------------
// Internal bus sizes and timing
// ----------------------------------------------------------------------
`define TCM_SIZE_BYTE 2'b00
`define TCM_SIZE_WORD 2'b01
`define TCM_SIZE_LONG 2'b10
`define TCM_INT_OPS 2'd3
`endif

// file: rtl/tcm_transfer_controller.v
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tcm_defines.vh"

// Behaviour
// - Register block holds first mode, source, second mode, destination, count A, count B.
// - Chained register blocks sit back to back and are fetched in sequence.
// - Normal mode moves one unit per activation, counting on count A only.
// - Normal count runs 1 to 65,536; count end may request a CPU interrupt.
// - Repeat mode moves one unit; at count end counter and area address reload.
// - Repeat mode never interrupts the CPU unless the per-transfer select is set.
// - Repeat mode: count A upper byte is reload value, lower byte runs.
// - Block mode moves a whole block; a mode bit picks the block-area side.
// - Block size 1 to 256; after each block counter and area address restore.
// - After a block the other address follows its own address mode.
// - Block mode counts blocks on count B; its end interrupts the CPU unless chain is enabled.
// - Chain enable runs the next description at once without a new request.
// - Chained descriptions raise no CPU interrupt and leave the source flag alone.
// - Sequence: vector read, six register accesses, data pairs, three internal states.
// - Software vector address is H'0400 plus vector number shifted left one.
// - Each vector is two bytes giving the low address bits in on-chip RAM.
module tcm_transfer_controller (
  // Clock and reset.
  input wire clk,
  input wire reset_n,
  // Wishbone register slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg wb_ack_o,
  output reg [31:0] wb_dat_o,
  // Peripheral activation.
  input wire hwReq,
  input wire [6:0] hwVector,
  output reg hwAck,
  output reg hwClearFlag,
  output reg hwClearEnable,
  output reg hwCpuReq,
  // Internal bus master.
  output reg busCyc,
  output reg busWe,
  output reg [23:0] busAddr,
  output reg [1:0] busSize,
  output reg [31:0] busWdata,
  input wire busAck,
  input wire [31:0] busRdata,
  // Interrupt and status.
  output reg irq,
  output reg busy
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_VEC = 8'h02;
  localparam [7:0] S_RI = 8'h04;
  localparam [7:0] S_RD = 8'h08;
  localparam [7:0] S_WR = 8'h10;
  localparam [7:0] S_INT = 8'h20;
  localparam [7:0] S_WB = 8'h40;
  localparam [7:0] S_END = 8'h80;

  // Next address of one unit step, by address mode (0x fixed, 10 up, 11 down).
  function [23:0] f_step;
    input [23:0] addr;
    input [1:0] mode;
    input sz;
    begin
      if (!mode[1])
        f_step = addr;
      else if (mode[0])
        f_step = addr - (sz ? 24'h00_0002 : 24'h00_0001);
      else
        f_step = addr + (sz ? 24'h00_0002 : 24'h00_0001);
    end
  endfunction

  // Undo a whole area of len bytes, bringing the area address back to its start.
  function [23:0] f_back;
    input [23:0] addr;
    input [1:0] mode;
    input [9:0] len;
    begin
      if (!mode[1])
        f_back = addr;
      else if (mode[0])
        f_back = addr + {14'h0000, len};
      else
        f_back = addr - {14'h0000, len};
    end
  endfunction

  reg [7:0] state;
  reg [1:0] riIdx;
  reg [1:0] intCnt;
  reg [7:0] mode_reg_first;
  reg [7:0] mode_reg_second;
  reg [23:0] src_addr_reg;
  reg [23:0] dst_addr_reg;
  reg [15:0] count_reg_a;
  reg [15:0] block_count_reg;
  reg [23:0] riBase;
  reg [15:0] dataLatch;
  reg countEnd;
  reg isSw;
  reg swArm;
  reg swte;
  reg [6:0] swVec;
  reg [1:0] stat;
  reg [1:0] mask;
  reg swEndEv;
  reg hwEndEv;
  reg swClrEv;

  wire wbHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // A write lands at the edge where the master sees ack, while it still holds the request.
  wire wbWr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire sz = mode_reg_first[`TCM_MRA_SZ];
  wire [1:0] md = mode_reg_first[`TCM_MRA_MD];
  wire [23:0] nextSar = f_step(src_addr_reg, mode_reg_first[`TCM_MRA_SM], sz);
  wire [23:0] nextDar = f_step(dst_addr_reg, mode_reg_first[`TCM_MRA_DM], sz);
  // Area length in bytes; a reload byte of zero means 256 units.
  wire [9:0] areaUnits = {1'b0, count_reg_a[15:8] == 8'h00, count_reg_a[15:8]};
  wire [9:0] areaLen = sz ? {areaUnits[8:0], 1'b0} : areaUnits;
  wire areaWrap = (md != `TCM_MD_NORMAL) && (count_reg_a[7:0] == 8'h01);
  wire srcArea = mode_reg_first[`TCM_MRA_DTS];

  // --------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------
  // Reads answer one cycle after the strobe; unmapped offsets read zero.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbHit;
      wb_dat_o <= 32'h0000_0000;
      if (wbHit && !wb_we_i) begin
        case (wb_adr_i)
          `TCM_OFS_SWVEC: wb_dat_o <= {24'h00_0000, swte, swVec};
          `TCM_OFS_STAT: wb_dat_o <= {30'h0000_0000, stat};
          `TCM_OFS_MASK: wb_dat_o <= {30'h0000_0000, mask};
          `TCM_OFS_STATE: wb_dat_o <= {24'h00_0000, state};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software activation word, sticky status and mask.
  // A hardware set beats a same-cycle write-one-to-clear, so no event is lost.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      swte <= 1'b0;
      swVec <= 7'h00;
      swArm <= 1'b0;
      stat <= 2'b00;
      mask <= 2'b00;
      irq <= 1'b0;
    end else begin
      if (wbWr && wb_adr_i == `TCM_OFS_SWVEC) begin
        swte <= wb_dat_i[`TCM_SWVEC_ARM];
        swVec <= wb_dat_i[6:0];
        swArm <= wb_dat_i[`TCM_SWVEC_ARM];
      end else begin
        if (swClrEv)
          swte <= 1'b0;
        if (state == S_IDLE && swArm)
          swArm <= 1'b0;
      end
      if (wbWr && wb_adr_i == `TCM_OFS_MASK)
        mask <= wb_dat_i[1:0];
      stat[`TCM_STAT_SWEND] <= swEndEv |
        (stat[`TCM_STAT_SWEND] & ~(wbWr && wb_adr_i == `TCM_OFS_STAT && wb_dat_i[0]));
      stat[`TCM_STAT_HWEND] <= hwEndEv |
        (stat[`TCM_STAT_HWEND] & ~(wbWr && wb_adr_i == `TCM_OFS_STAT && wb_dat_i[1]));
      irq <= |(stat & mask);
    end
  end

  // --------------------------------------------------------------------
  // Transfer sequencer and bus master
  // --------------------------------------------------------------------
  // Each access is held until ack, then the bus idles at least one cycle before the next.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      riIdx <= 2'd0;
      intCnt <= 2'd0;
      mode_reg_first <= 8'h00;
      mode_reg_second <= 8'h00;
      src_addr_reg <= 24'h00_0000;
      dst_addr_reg <= 24'h00_0000;
      count_reg_a <= 16'h0000;
      block_count_reg <= 16'h0000;
      riBase <= 24'h00_0000;
      dataLatch <= 16'h0000;
      countEnd <= 1'b0;
      isSw <= 1'b0;
      busCyc <= 1'b0;
      busWe <= 1'b0;
      busAddr <= 24'h00_0000;
      busSize <= `TCM_SIZE_BYTE;
      busWdata <= 32'h0000_0000;
      hwAck <= 1'b0;
      hwClearFlag <= 1'b0;
      hwClearEnable <= 1'b0;
      hwCpuReq <= 1'b0;
      swEndEv <= 1'b0;
      hwEndEv <= 1'b0;
      swClrEv <= 1'b0;
      busy <= 1'b0;
    end else begin
      hwAck <= 1'b0;
      hwClearFlag <= 1'b0;
      hwClearEnable <= 1'b0;
      hwCpuReq <= 1'b0;
      swEndEv <= 1'b0;
      hwEndEv <= 1'b0;
      swClrEv <= 1'b0;
      busy <= (state != S_IDLE);
      if (busCyc) begin
        // Completion of the access in flight.
        if (busAck) begin
          busCyc <= 1'b0;
          busWe <= 1'b0;
          case (state)
            S_VEC: begin
              riBase <= {`TCM_RAM_HIGH, busRdata[15:0]};
              riIdx <= 2'd0;
              state <= S_RI;
            end
            S_RI: begin
              case (riIdx)
                2'd0: {mode_reg_first, src_addr_reg} <= busRdata;
                2'd1: {mode_reg_second, dst_addr_reg} <= busRdata;
                default: {count_reg_a, block_count_reg} <= busRdata;
              endcase
              riIdx <= riIdx + 2'd1;
              if (riIdx == 2'd2)
                state <= S_RD;
            end
            S_RD: begin
              dataLatch <= busRdata[15:0];
              state <= S_WR;
            end
            S_WR: begin
              src_addr_reg <= nextSar;
              dst_addr_reg <= nextDar;
              state <= S_INT;
              case (md)
                `TCM_MD_REPEAT: begin
                  // Count end reloads at one; countEnd stays clear in repeat mode.
                  countEnd <= 1'b0;
                  if (areaWrap) begin
                    count_reg_a[7:0] <= count_reg_a[15:8];
                    if (srcArea)
                      src_addr_reg <= f_back(nextSar, mode_reg_first[`TCM_MRA_SM], areaLen);
                    else
                      dst_addr_reg <= f_back(nextDar, mode_reg_first[`TCM_MRA_DM], areaLen);
                  end else begin
                    count_reg_a[7:0] <= count_reg_a[7:0] - 8'h01;
                  end
                end
                `TCM_MD_BLOCK: begin
                  // Whole block per activation; area side picked by mode bit.
                  if (areaWrap) begin
                    count_reg_a[7:0] <= count_reg_a[15:8];
                    if (srcArea)
                      src_addr_reg <= f_back(nextSar, mode_reg_first[`TCM_MRA_SM], areaLen);
                    else
                      dst_addr_reg <= f_back(nextDar, mode_reg_first[`TCM_MRA_DM], areaLen);
                    // The other side keeps the advance of its own mode.
                    block_count_reg <= block_count_reg - 16'h0001;
                    countEnd <= (block_count_reg == 16'h0001);
                  end else begin
                    count_reg_a[7:0] <= count_reg_a[7:0] - 8'h01;
                    state <= S_RD;
                  end
                end
                default: begin
                  // Zero in count A means 65,536 transfers.
                  count_reg_a <= count_reg_a - 16'h0001;
                  countEnd <= (count_reg_a == 16'h0001);
                end
              endcase
            end
            S_WB: begin
              riIdx <= riIdx + 2'd1;
              if (riIdx == 2'd2)
                state <= S_END;
            end
            default: state <= state;
          endcase
        end
      end else begin
        case (state)
          S_IDLE: begin
            // Software activation has the higher priority.
            if (swArm || hwReq) begin
              isSw <= swArm;
              hwAck <= ~swArm;
              busAddr <= `TCM_VEC_BASE + {16'h0000, swArm ? swVec : hwVector, 1'b0};
              busSize <= `TCM_SIZE_WORD;
              busCyc <= 1'b1;
              state <= S_VEC;
            end
          end
          S_RI: begin
            busAddr <= riBase + {20'h0_0000, riIdx, 2'b00};
            busSize <= `TCM_SIZE_LONG;
            busCyc <= 1'b1;
          end
          S_RD: begin
            busAddr <= src_addr_reg;
            busSize <= sz ? `TCM_SIZE_WORD : `TCM_SIZE_BYTE;
            busCyc <= 1'b1;
          end
          S_WR: begin
            busAddr <= dst_addr_reg;
            busWe <= 1'b1;
            busWdata <= {16'h0000, sz ? dataLatch : {8'h00, dataLatch[7:0]}};
            busCyc <= 1'b1;
          end
          S_INT: begin
            // Three internal-operation states close the data phase.
            intCnt <= intCnt + 2'd1;
            if (intCnt == `TCM_INT_OPS - 2'd1) begin
              intCnt <= 2'd0;
              riIdx <= 2'd0;
              state <= S_WB;
            end
          end
          S_WB: begin
            // Updated description goes back to its own block.
            busAddr <= riBase + {20'h0_0000, riIdx, 2'b00};
            busSize <= `TCM_SIZE_LONG;
            busWe <= 1'b1;
            case (riIdx)
              2'd0: busWdata <= {mode_reg_first, src_addr_reg};
              2'd1: busWdata <= {mode_reg_second, dst_addr_reg};
              default: busWdata <= {count_reg_a, block_count_reg};
            endcase
            busCyc <= 1'b1;
          end
          S_END: begin
            if (mode_reg_second[`TCM_MRB_CHAIN]) begin
              // Next description follows at once, no interrupt, flag left.
              riBase <= riBase + `TCM_RI_STRIDE;
              riIdx <= 2'd0;
              state <= S_RI;
            end else begin
              state <= S_IDLE;
              if (countEnd || mode_reg_second[`TCM_MRB_EACH]) begin
                // Count end or per-transfer select interrupts the CPU.
                swEndEv <= isSw;
                hwEndEv <= ~isSw;
                hwCpuReq <= ~isSw;
                hwClearEnable <= ~isSw;
              end else begin
                swClrEv <= isSw;
                hwClearFlag <= ~isSw;
              end
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

endmodule // tcm_transfer_controller

// file: verification/tcm_bus_memory.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Internal bus partner: byte memory with random wait states
// ----------------------------------------------------------------------
module tcm_bus_memory (
  // Clock and reset.
  input wire clk,
  input wire reset_n,
  // Access request from the sequencer.
  input wire busCyc,
  input wire busWe,
  input wire [23:0] busAddr,
  input wire [1:0] busSize,
  input wire [31:0] busWdata,
  // Answer.
  output logic busAck,
  output logic [31:0] busRdata
);
  logic [7:0] m [int];
  int n, k;
  logic [31:0] r;
  // Big-endian storage keeps the register block as software lays it out.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busAck <= 1'b0;
      busRdata <= 32'h0000_0000;
    end else if (busAck) begin
      // A write lands only at the edge where the sequencer samples the answer.
      if (busWe) for (k = 0; k < n; k++) m[busAddr + k] = busWdata[8 * (n - 1 - k) +: 8];
      busAck <= 1'b0;
      busRdata <= $urandom;
    end else if (busCyc && $urandom % 3 == 0) begin
      n = 1 << busSize;
      r = 0;
      for (k = 0; k < n; k++) r = (r << 8) | m[busAddr + k];
      busRdata <= r;
      busAck <= 1'b1;
    end else begin
      busRdata <= $urandom; // Stale data must never look valid.
    end
  end
endmodule // tcm_bus_memory

// file: verification/tcm_checker_monitor.sv
`timescale 1ns/1ps
`include "tcm_defines.vh"
// ----------------------------------------------------------------------
// Port checker of the transfer sequencer
// ----------------------------------------------------------------------
module tcm_checker_monitor (
  // Clock and reset.
  input wire clk,
  input wire reset_n,
  // Register bus.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Activation side.
  input wire hwAck,
  input wire [6:0] hwVector,
  input wire hwCpuReq,
  input wire hwClearEnable,
  input wire hwClearFlag,
  // Internal bus.
  input wire busCyc,
  input wire busWe,
  input wire [23:0] busAddr,
  input wire [1:0] busSize,
  input wire [31:0] busWdata,
  input wire busAck
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Handshakes, vector fetch and end pulses.
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("register ack not a single pulse");
  AST_VEC_ADDR: assert property (hwAck |-> busCyc && !busWe &&
    busSize == `TCM_SIZE_WORD && busAddr == `TCM_VEC_BASE + {hwVector, 1'b0})
    else $error("vector fetch address wrong");
  AST_BUS_HOLD: assert property (busCyc && !busAck |=> busCyc && $stable(busAddr) &&
    $stable(busWe) && $stable(busSize) && $stable(busWdata)) else $error("bus request moved");
  AST_BUS_GAP: assert property (busAck |=> !busCyc) else $error("no idle after access");
  AST_RI_RAM: assert property (busCyc && busSize == `TCM_SIZE_LONG |->
    busAddr[23:16] == 8'hFF && busAddr[1:0] == 2'b00) else $error("register access off RAM");
  AST_CPU_PAIR: assert property (hwCpuReq |-> hwClearEnable && !hwClearFlag)
    else $error("cpu request without enable clear");
  AST_END_ONE: assert property (hwCpuReq || hwClearFlag |=> !hwCpuReq && !hwClearFlag)
    else $error("end pulse too long");
  // The pulse leaves the end state one cycle after the closing ack, so look two edges back.
  AST_END_AFTER_WB: assert property (hwCpuReq || hwClearFlag |-> $past(busAck, 2) &&
    $past(busWe, 2) && $past(busSize, 2) == `TCM_SIZE_LONG) else $error("end before write back");
endmodule // tcm_checker_monitor

bind tcm_transfer_controller tcm_checker_monitor chk (.clk(clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .hwAck(hwAck),
  .hwVector(hwVector), .hwCpuReq(hwCpuReq), .hwClearEnable(hwClearEnable),
  .hwClearFlag(hwClearFlag), .busCyc(busCyc), .busWe(busWe), .busAddr(busAddr),
  .busSize(busSize), .busWdata(busWdata), .busAck(busAck));

// file: verification/testbench.sv
`timescale 1ns/1ps
`include "tcm_defines.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
// ----------------------------------------------------------------------
// Self-checking bench of the transfer sequencer
// ----------------------------------------------------------------------
module testbench;
  logic clk = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, hwReq = 0;
  logic [3:0] wb_adr_i = '0, wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, busWdata, busRdata;
  logic [6:0] hwVector = '0;
  logic [23:0] busAddr;
  logic [1:0] busSize;
  logic wb_ack_o, hwAck, hwClearFlag, hwClearEnable, hwCpuReq, busCyc, busWe, busAck, irq, busy;
  logic [7:0] em [int];
  int n_mismatch = 0, n_compared = 0, nCpu, nFlag, nTest = 0;
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  tcm_transfer_controller dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .hwReq(hwReq),
    .hwVector(hwVector), .hwAck(hwAck), .hwClearFlag(hwClearFlag),
    .hwClearEnable(hwClearEnable), .hwCpuReq(hwCpuReq), .busCyc(busCyc), .busWe(busWe),
    .busAddr(busAddr), .busSize(busSize), .busWdata(busWdata), .busAck(busAck),
    .busRdata(busRdata), .irq(irq), .busy(busy));
  tcm_bus_memory mem (.clk(clk), .reset_n(reset_n), .busCyc(busCyc), .busWe(busWe),
    .busAddr(busAddr), .busSize(busSize), .busWdata(busWdata), .busAck(busAck),
    .busRdata(busRdata));
  // Counts end pulses; each is one cycle wide, so a sum tells doubles apart.
  always @(posedge clk) begin
    nCpu += hwCpuReq;
    nFlag += hwClearFlag;
  end
  // One classic Wishbone cycle; the master holds everything until ack.
  task automatic wbx(input bit we, input [3:0] a, input [31:0] d, output [31:0] r);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic w8(input int a, input [7:0] x); mem.m[a] = x; em[a] = x; endtask
  task automatic w32(input int a, input [31:0] x);
    for (int i = 0; i < 4; i++) w8(a + i, x[31 - 8 * i -: 8]);
  endtask
  function automatic int rd(input int a, input int n);
    rd = 0;
    for (int i = 0; i < n; i++) rd = (rd << 8) | em[a + i];
  endfunction
  function automatic int stp(input [1:0] m, input int u);
    return m[1] ? (m[0] ? -u : u) : 0;
  endfunction
  // Reference model: walks the chain and moves bytes in the shadow memory.
  task automatic model(input int v, output bit f);
    int b, s, d, ss, ds, u, n, i, k, ca, cb, ah;
    logic [7:0] ma, mb;
    b = {8'hFF, em['h400 + 2 * v], em['h401 + 2 * v]};
    do begin
      ma = em[b]; s = rd(b + 1, 3); mb = em[b + 4]; d = rd(b + 5, 3);
      ca = rd(b + 8, 2); cb = rd(b + 10, 2);
      u = ma[0] + 1; ss = stp(ma[7:6], u); ds = stp(ma[5:4], u);
      ah = ca[15:8] ? ca[15:8] : 256;
      n = ma[3:2] == 2 ? ah : 1;
      for (i = 0; i < n; i++) begin
        for (k = 0; k < u; k++) em[(d + k) & 'hFFFFFF] = em[(s + k) & 'hFFFFFF];
        s += ss; d += ds;
      end
      f = mb[6];
      if (ma[3:2] == 0) begin ca = (ca - 1) & 'hFFFF; f |= ca == 0; end
      else if (ma[3:2] == 1 && ca[7:0] == 1 || ma[3:2] == 2) begin
        if (ma[1]) s -= ss * ah; else d -= ds * ah;
        ca = (ca & 'hFF00) | ca[15:8];
        if (ma[3:2] == 2) begin cb = (cb - 1) & 'hFFFF; f |= cb == 0; end
      end else ca = ca - 1;
      w32(b, {ma, s[23:0]}); w32(b + 4, {mb, d[23:0]}); w32(b + 8, {ca[15:0], cb[15:0]});
      b += 12;
    end while (mb[7]);
  endtask
  // One activation: place blocks, start, wait for idle, compare everything.
  task automatic tst(input bit sw, input [1:0] mk, input [7:0] ma, mb, input [15:0] ca, cb);
    int b, v, a, k, s, d;
    bit f;
    logic [1:0] e;
    logic [31:0] r;
    b = 'hFFF800 + nTest * 32;
    v = 16 + nTest * 8 + $urandom % 8;
    nCpu = 0; nFlag = 0;
    w8('h400 + 2 * v, b[15:8]); w8('h401 + 2 * v, b[7:0]);
    for (k = 0; k < (mb[7] ? 2 : 1); k++) begin
      s = 'hFFF920 + $urandom % 64 * 2; d = 'hFFFA20 + $urandom % 64 * 2;
      w32(b + 12 * k, {k ? 8'hA9 : ma, s[23:0]}); w32(b + 12 * k + 4, {k ? 8'h00 : mb, d[23:0]});
      w32(b + 12 * k + 8, k ? 32'h0202_0002 : {ca, cb});
    end
    wbx(1, `TCM_OFS_MASK, mk, r);
    if (sw) wbx(1, `TCM_OFS_SWVEC, 32'h0000_0080 | v, r);
    else begin
      hwVector <= v[6:0]; hwReq <= 1'b1;
      do @(posedge clk); while (hwAck !== 1'b1);
      hwReq <= 1'b0;
    end
    repeat (3) @(posedge clk);
    for (k = 0; k < 5000 && busy !== 1'b0; k++) @(posedge clk);
    model(v, f);
    for (a = 'hFFF800; a < 'hFFFC00; a++) `CHK(mem.m[a], em[a])
    e = f ? (sw ? 2'b01 : 2'b10) : 2'b00;
    wbx(0, `TCM_OFS_STAT, 0, r);
    `CHK(r[1:0], e)
    `CHK(irq, |(e & mk))
    if (sw) begin wbx(0, `TCM_OFS_SWVEC, 0, r); `CHK(r[7:0], ({f, v[6:0]})) end
    else begin `CHK(nCpu, int'(f)) `CHK(nFlag, int'(!f)) end
    wbx(1, `TCM_OFS_STAT, 3, r); wbx(1, `TCM_OFS_SWVEC, 0, r);
    `CHK(irq, 1'b0)
    $display("test %0d done", nTest);
    nTest++;
  endtask
  task automatic report_and_stop;
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard, far beyond the several hundred cycles the tests need.
  initial begin
    #200_000;
    n_mismatch++;
    report_and_stop;
  end
  // Main sequence: preload memory, release reset, run modes, check odd registers.
  initial begin
    logic [31:0] r;
    void'($urandom(32'h931a_fbcd));
    for (int a = 'h400; a < 'h500; a++) w8(a, $urandom);
    for (int a = 'hFFF800; a < 'hFFFC00; a++) w8(a, $urandom);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    tst(1, 2'b11, 8'hA0, 8'h00, 16'h0001, 16'h0000);
    tst(0, 2'b11, 8'hF1, 8'h00, 16'h0005, 16'h1234);
    tst(0, 2'b11, 8'h24, 8'h00, 16'h0101, 16'h0000);
    tst(1, 2'b01, 8'hAB, 8'h00, 16'h0303, 16'h0001);
    tst(0, 2'b10, 8'h80, 8'hC0, 16'h0003, 16'h0000);
    tst(0, 2'b11, 8'h26, 8'h40, 16'h0202, 16'h0000);
    tst(1, 2'b10, 8'hA0, 8'h00, 16'h0000, 16'h0000);
    wbx(0, 4'h2, 0, r);
    `CHK(r, 32'h0000_0000)
    wbx(0, `TCM_OFS_STATE, 0, r);
    `CHK(r[7:0], 8'h01)
    report_and_stop;
  end
endmodule // testbench
